// *** cms_pkg.sv ***
// Package for the core status word and data memory map block.
// Assumes a single core clock; shared by the map and its expanded RAM.
package cms_pkg;

	// Special register addresses
	localparam logic [7:0] SFR_SP = 8'h81;
	localparam logic [7:0] SFR_DPL = 8'h82;
	localparam logic [7:0] SFR_DPH = 8'h83;
	localparam logic [7:0] SFR_XPAGE = 8'haa;
	localparam logic [7:0] SFR_PSW = 8'hd0;
	localparam logic [7:0] SFR_ACC = 8'he0;
	localparam logic [7:0] SFR_B = 8'hf0;

	// Status word field positions
	localparam int PSW_CY = 7;
	localparam int PSW_AC = 6;
	localparam int PSW_F0 = 5;
	localparam int PSW_RS_HI = 4;
	localparam int PSW_RS_LO = 3;
	localparam int PSW_OV = 2;
	localparam int PSW_F1 = 1;
	localparam int PSW_PAR = 0;

	// Reset values
	localparam logic [7:0] PSW_RST = 8'h00;
	localparam logic [7:0] SP_RST = 8'h07;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// Memory map
	localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
	localparam logic [7:0] SFR_BIT_MASK = 8'hf8;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	localparam int RAM_DEPTH = 256;
	localparam int EXPANDED_DATA_RAM_AW = 12;
	localparam int EXPANDED_DATA_RAM_DEPTH = 4096;
	localparam logic [15:0] FLASH_TOP_LARGE = 16'hfbff;
	localparam logic [15:0] FLASH_TOP_SMALL = 16'h7fff;

	// Operations handed over by instruction execution
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_ADD = 5'h01,
		OP_ADDC = 5'h02,
		OP_SUBB = 5'h03,
		OP_MUL = 5'h04,
		OP_DIV = 5'h05,
		OP_DIR_RD = 5'h06,
		OP_DIR_WR = 5'h07,
		OP_IND_RD = 5'h08,
		OP_IND_WR = 5'h09,
		OP_BIT_RD = 5'h0a,
		OP_BIT_WR = 5'h0b,
		OP_REG_RD = 5'h0c,
		OP_REG_WR = 5'h0d,
		OP_PUSH = 5'h0e,
		OP_POP = 5'h0f,
		OP_XMOV_RD = 5'h10,
		OP_XMOV_WR = 5'h11,
		OP_CODE_RD = 5'h12
	} cms_op_t;

	typedef struct packed {
		cms_op_t op;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic ptr_sel;
		logic use_wide_data_pointer;
	} cms_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} cms_rsp_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [7:0] data;
		logic lock_hit;
		logic reserved;
	} cms_flash_t;

endpackage

// *** cms_expanded_data_ram.sv ***
// Expanded on-chip data RAM, 4096 bytes.
// Assumes writes and reads come from the map on the same core clock.
`timescale 1ns/1ns
`default_nettype none

module cms_expanded_data_ram (
	input wire logic clk_in,
	input wire logic we_in,
	input wire logic [cms_pkg::EXPANDED_DATA_RAM_AW-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);

	logic [7:0] mem_r [cms_pkg::EXPANDED_DATA_RAM_DEPTH];

	// Array holds no reset; contents are undefined until written
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem_r[addr_in] <= wdata_in;
		end
	end

	// Read is combinational so the map can register it with other answers
	assign rdata_out = mem_r[addr_in];

endmodule
`default_nettype wire

// *** cms_core_map.sv ***
// Status word, internal RAM, stack and expanded RAM decode of a small core.
// Assumes one request per cycle from instruction execution on CLK_IN.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Carry bit 7 set on add carry or subtract borrow, else cleared.
// - Half-carry bit 6 set on nibble carry or borrow, else cleared.
// - Bits 5 and 1 are plain software flags, bit-addressable.
// - Bank select bits 4:3 pick register bytes 0x00, 0x08, 0x10 or 0x18.
// - Overflow bit 2 set on signed overflow of add, add-carry, subtract.
// - Overflow set when product exceeds 255 or divisor is zero.
// - Those instructions clear overflow when their condition is absent.
// - Bit 0 is read-only odd parity of the accumulator.
// - Status word at special address 0xD0, bit access, resets to zero.
// - Flash runs from 0x0000 to top; top byte is lock, above reserved.
// - Code reads via code-read op; external writes go to RAM or flash.
// - Program and data spaces are chosen by the instruction type, and by FLASH_WR_SEL_IN for external writes.
// - Lower 128 RAM bytes reachable directly and indirectly.
// - Above 0x7F direct hits special registers, indirect hits upper RAM.
// - Bytes 0x20-0x2F give 128 bits; bit n is byte 0x20+n/8 bit n%8.
// - Bit or byte access follows the operand type of the instruction.
// - One bank active; its first two registers are the index pointers.
// - Push advances the pointer first, then writes at the new place.
// - Reset loads the stack pointer with 0x07.
// - Stack may sit anywhere in the 256 bytes of internal RAM.
// - 4096-byte expanded RAM addressed by data pointer or page plus index.
module cms_core_map #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire cms_pkg::cms_req_t REQ_IN,
	input wire logic FLASH_WR_SEL_IN,
	output cms_pkg::cms_rsp_t RSP_OUT,
	output cms_pkg::cms_flash_t FLASH_REQ_OUT,
	output logic [7:0] PSW_OUT,
	output logic [7:0] SP_OUT,
	output logic [7:0] ACC_OUT
);

	////////////////////////////////////////////////////////////////////////
	// State

	localparam logic [15:0] FLASH_TOP = LARGE_VARIANT ? cms_pkg::FLASH_TOP_LARGE
		: cms_pkg::FLASH_TOP_SMALL;

	logic [7:0] ram_r [cms_pkg::RAM_DEPTH];
	logic [7:0] psw_r, sp_r, acc_r, b_r, dpl_r, dph_r, page_r;
	logic [7:0] acc_nxt, b_nxt, flags_nxt;
	logic arith_en;
	logic [1:0] bank;
	logic [7:0] ri_addr, reg_addr, ind_ptr, bit_byte, bit_old, bit_new;
	logic [7:0] wr_addr, wr_data, sfr_rd, stack_byte, rdata_nxt;
	logic wr_en, wr_sfr, expanded_data_ram_we, expanded_data_ram_hit;
	logic [15:0] xaddr;
	logic [7:0] expanded_data_ram_rdata;
	cms_pkg::cms_op_t op;

	assign op = REQ_IN.op;
	assign bank = psw_r[cms_pkg::PSW_RS_HI:cms_pkg::PSW_RS_LO];

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Special register read, shared by byte and bit paths
	function automatic logic [7:0] sfr_read(input logic [7:0] a);
		unique case (a)
			cms_pkg::SFR_SP: sfr_read = sp_r;
			cms_pkg::SFR_DPL: sfr_read = dpl_r;
			cms_pkg::SFR_DPH: sfr_read = dph_r;
			cms_pkg::SFR_XPAGE: sfr_read = page_r;
			cms_pkg::SFR_PSW: sfr_read = psw_r;
			cms_pkg::SFR_ACC: sfr_read = acc_r;
			cms_pkg::SFR_B: sfr_read = b_r;
			default: sfr_read = cms_pkg::UNMAPPED_RD;
		endcase
	endfunction

	// Bit address to owning byte: low half maps onto 0x20-0x2F
	function automatic logic [7:0] bit_to_byte(input logic [7:0] n);
		if (n[7]) begin
			bit_to_byte = n & cms_pkg::SFR_BIT_MASK;
		end else begin
			bit_to_byte = cms_pkg::BIT_BYTE_BASE + {4'h0, n[6:3]};
		end
	endfunction

	// Direct access: upper half is special registers, never upper RAM
	function automatic logic [7:0] direct_read(input logic [7:0] a);
		direct_read = a[7] ? sfr_read(a) : ram_r[a];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Address decode

	// Bank-relative registers; R0 and R1 of the active bank are the pointers
	always_comb begin
		reg_addr = {3'h0, bank, REQ_IN.addr[2:0]};
		ri_addr = {3'h0, bank, 2'h0, REQ_IN.ptr_sel};
		ind_ptr = ram_r[ri_addr];
		bit_byte = bit_to_byte(REQ_IN.addr[7:0]);
		bit_old = direct_read(bit_byte);
		bit_new = bit_old;
		bit_new[REQ_IN.addr[2:0]] = REQ_IN.wdata[0];
		stack_byte = ram_r[sp_r];
		sfr_rd = direct_read(REQ_IN.addr[7:0]);
	end

	// Expanded RAM address: data pointer or page byte over index register
	always_comb begin
		xaddr = REQ_IN.use_wide_data_pointer ? {dph_r, dpl_r} : {page_r, ind_ptr};
		expanded_data_ram_hit = (xaddr < 16'(cms_pkg::EXPANDED_DATA_RAM_DEPTH));
		// Write is steered to flash when reconfigured; off-chip is not modelled
		expanded_data_ram_we = (op == cms_pkg::OP_XMOV_WR) && expanded_data_ram_hit && !FLASH_WR_SEL_IN;
	end

	// One byte-write path for direct, indirect, register, bit and push
	always_comb begin
		wr_en = 1'b0;
		wr_sfr = 1'b0;
		wr_addr = REQ_IN.addr[7:0];
		wr_data = REQ_IN.wdata;
		unique case (op)
			cms_pkg::OP_DIR_WR: begin
				wr_en = 1'b1;
				wr_sfr = REQ_IN.addr[7];
			end
			cms_pkg::OP_IND_WR: begin
				wr_en = 1'b1;
				wr_addr = ind_ptr;
			end
			cms_pkg::OP_REG_WR: begin
				wr_en = 1'b1;
				wr_addr = reg_addr;
			end
			cms_pkg::OP_BIT_WR: begin
				wr_en = 1'b1;
				wr_sfr = bit_byte[7];
				wr_addr = bit_byte;
				wr_data = bit_new;
			end
			cms_pkg::OP_PUSH: begin
				wr_en = 1'b1;
				wr_addr = sp_r + 8'h01;
			end
			default: begin
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Arithmetic and flags

	// Flags other than bank and software bits come from the last operation
	always_comb begin
		logic [8:0] full;
		logic [4:0] nib;
		logic [15:0] prod;
		logic cin;
		full = 9'h000;
		nib = 5'h00;
		prod = acc_r * b_r;
		cin = (op == cms_pkg::OP_ADDC || op == cms_pkg::OP_SUBB) && psw_r[cms_pkg::PSW_CY];
		acc_nxt = acc_r;
		b_nxt = b_r;
		flags_nxt = psw_r;
		arith_en = 1'b1;
		unique case (op)
			cms_pkg::OP_ADD, cms_pkg::OP_ADDC: begin
				full = {1'b0, acc_r} + {1'b0, REQ_IN.wdata} + {8'h00, cin};
				nib = {1'b0, acc_r[3:0]} + {1'b0, REQ_IN.wdata[3:0]} + {4'h0, cin};
				acc_nxt = full[7:0];
				flags_nxt[cms_pkg::PSW_CY] = full[8];
				flags_nxt[cms_pkg::PSW_AC] = nib[4];
				flags_nxt[cms_pkg::PSW_OV] = (acc_r[7] == REQ_IN.wdata[7])
					&& (full[7] != acc_r[7]);
			end
			cms_pkg::OP_SUBB: begin
				full = {1'b0, acc_r} - {1'b0, REQ_IN.wdata} - {8'h00, cin};
				nib = {1'b0, acc_r[3:0]} - {1'b0, REQ_IN.wdata[3:0]} - {4'h0, cin};
				acc_nxt = full[7:0];
				flags_nxt[cms_pkg::PSW_CY] = full[8];
				flags_nxt[cms_pkg::PSW_AC] = nib[4];
				flags_nxt[cms_pkg::PSW_OV] = (acc_r[7] != REQ_IN.wdata[7])
					&& (full[7] != acc_r[7]);
			end
			cms_pkg::OP_MUL: begin
				acc_nxt = prod[7:0];
				b_nxt = prod[15:8];
				flags_nxt[cms_pkg::PSW_CY] = 1'b0;
				flags_nxt[cms_pkg::PSW_AC] = 1'b0;
				flags_nxt[cms_pkg::PSW_OV] = |prod[15:8];
			end
			cms_pkg::OP_DIV: begin
				// Zero divisor leaves both operands untouched
				if (b_r != 8'h00) begin
					acc_nxt = acc_r / b_r;
					b_nxt = acc_r % b_r;
				end
				flags_nxt[cms_pkg::PSW_CY] = 1'b0;
				flags_nxt[cms_pkg::PSW_AC] = 1'b0;
				flags_nxt[cms_pkg::PSW_OV] = (b_r == 8'h00);
			end
			default: begin
				arith_en = 1'b0;
				if (wr_en && wr_sfr) begin
					unique case (wr_addr)
						cms_pkg::SFR_ACC: acc_nxt = wr_data;
						cms_pkg::SFR_B: b_nxt = wr_data;
						cms_pkg::SFR_PSW: flags_nxt = wr_data;
						default: begin
						end
					endcase
				end
			end
		endcase
		// Parity always follows the accumulator, whatever software wrote
		flags_nxt[cms_pkg::PSW_PAR] = ^acc_nxt;
	end

	// Status word, accumulator and second operand
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			psw_r <= cms_pkg::PSW_RST;
			acc_r <= cms_pkg::BYTE_RST;
			b_r <= cms_pkg::BYTE_RST;
		end else begin
			psw_r <= flags_nxt;
			acc_r <= acc_nxt;
			b_r <= b_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pointers

	// Stack pointer: pre-increment on push, post-decrement on pop
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			sp_r <= cms_pkg::SP_RST;
		end else if (op == cms_pkg::OP_PUSH) begin
			sp_r <= sp_r + 8'h01;
		end else if (op == cms_pkg::OP_POP) begin
			sp_r <= sp_r - 8'h01;
		end else if (wr_en && wr_sfr && wr_addr == cms_pkg::SFR_SP) begin
			sp_r <= wr_data;
		end
	end

	// Data pointer halves and expanded RAM page byte
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			dpl_r <= cms_pkg::BYTE_RST;
			dph_r <= cms_pkg::BYTE_RST;
			page_r <= cms_pkg::BYTE_RST;
		end else if (wr_en && wr_sfr) begin
			if (wr_addr == cms_pkg::SFR_DPL) begin
				dpl_r <= wr_data;
			end
			if (wr_addr == cms_pkg::SFR_DPH) begin
				dph_r <= wr_data;
			end
			if (wr_addr == cms_pkg::SFR_XPAGE) begin
				page_r <= wr_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memories

	// Internal RAM; not reset, like any scratch memory
	always_ff @(posedge CLK_IN) begin
		if (wr_en && !wr_sfr) begin
			ram_r[wr_addr] <= wr_data;
		end
	end

	cms_expanded_data_ram u_expanded_data_ram (
		.clk_in(CLK_IN),
		.we_in(expanded_data_ram_we),
		.addr_in(xaddr[cms_pkg::EXPANDED_DATA_RAM_AW-1:0]),
		.wdata_in(REQ_IN.wdata),
		.rdata_out(expanded_data_ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Answers

	// Read data: the opcode picks the space; direct reads split on address bit 7
	always_comb begin
		unique case (op)
			cms_pkg::OP_DIR_RD: rdata_nxt = sfr_rd;
			cms_pkg::OP_IND_RD: rdata_nxt = ram_r[ind_ptr];
			cms_pkg::OP_REG_RD: rdata_nxt = ram_r[reg_addr];
			cms_pkg::OP_BIT_RD: rdata_nxt = {7'h00, bit_old[REQ_IN.addr[2:0]]};
			cms_pkg::OP_POP: rdata_nxt = stack_byte;
			cms_pkg::OP_XMOV_RD: rdata_nxt = expanded_data_ram_hit ? expanded_data_ram_rdata : cms_pkg::UNMAPPED_RD;
			default: rdata_nxt = cms_pkg::UNMAPPED_RD;
		endcase
	end

	// Response is one cycle after the request
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			RSP_OUT <= '0;
		end else begin
			RSP_OUT.valid <= op inside {cms_pkg::OP_DIR_RD, cms_pkg::OP_IND_RD,
				cms_pkg::OP_REG_RD, cms_pkg::OP_BIT_RD, cms_pkg::OP_POP,
				cms_pkg::OP_XMOV_RD};
			RSP_OUT.rdata <= rdata_nxt;
		end
	end

	// Flash requests: code reads, and external writes when redirected
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			FLASH_REQ_OUT <= '0;
		end else begin
			FLASH_REQ_OUT.valid <= (op == cms_pkg::OP_CODE_RD)
				|| (op == cms_pkg::OP_XMOV_WR && FLASH_WR_SEL_IN);
			FLASH_REQ_OUT.write <= (op == cms_pkg::OP_XMOV_WR);
			FLASH_REQ_OUT.addr <= (op == cms_pkg::OP_CODE_RD) ? REQ_IN.addr : xaddr;
			FLASH_REQ_OUT.data <= REQ_IN.wdata;
			FLASH_REQ_OUT.lock_hit <= ((op == cms_pkg::OP_CODE_RD) ? REQ_IN.addr : xaddr)
				== FLASH_TOP;
			FLASH_REQ_OUT.reserved <= ((op == cms_pkg::OP_CODE_RD) ? REQ_IN.addr : xaddr)
				> FLASH_TOP;
		end
	end

	assign PSW_OUT = psw_r;
	assign SP_OUT = sp_r;
	assign ACC_OUT = acc_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_push_req;
		op == cms_pkg::OP_PUSH;
	endsequence

	sequence s_pop_req;
		op == cms_pkg::OP_POP;
	endsequence

	chk_carry_add: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		op == cms_pkg::OP_ADD |=> psw_r[cms_pkg::PSW_CY]
			== $past(({1'b0, acc_r} + {1'b0, REQ_IN.wdata}) > 9'h0ff))
		else $error("carry flag wrong after add");

	chk_mul_flags: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		op == cms_pkg::OP_MUL |=> !psw_r[cms_pkg::PSW_CY] && !psw_r[cms_pkg::PSW_AC]
			&& psw_r[cms_pkg::PSW_OV] == (b_r != 8'h00))
		else $error("flags wrong after multiply");

	chk_div_zero: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		op == cms_pkg::OP_DIV && b_r == 8'h00 |=> psw_r[cms_pkg::PSW_OV]
			&& $stable(acc_r))
		else $error("divide by zero not flagged");

	chk_parity_track: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		PSW_OUT[cms_pkg::PSW_PAR] == ^ACC_OUT)
		else $error("parity does not match accumulator");

	chk_sp_reset: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		$rose(RST_B_IN) |-> sp_r == cms_pkg::SP_RST)
		else $error("stack pointer reset value wrong");

	chk_push_order: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		s_push_req |=> sp_r == $past(sp_r) + 8'h01 && ram_r[sp_r] == $past(REQ_IN.wdata))
		else $error("push did not pre-increment");

	chk_pop_order: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		s_pop_req |=> RSP_OUT.valid && RSP_OUT.rdata == $past(stack_byte)
			&& sp_r == $past(sp_r) - 8'h01)
		else $error("pop read or decrement wrong");

	chk_direct_sfr: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		op == cms_pkg::OP_DIR_WR && REQ_IN.addr[7:0] == cms_pkg::SFR_SP
			|=> sp_r == $past(REQ_IN.wdata))
		else $error("direct write missed special register");

	// Non-arithmetic ops that do not write the status word leave its flags other than parity alone
	chk_flags_hold: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		!arith_en && !(wr_en && wr_sfr && wr_addr == cms_pkg::SFR_PSW)
			|=> psw_r[cms_pkg::PSW_CY:cms_pkg::PSW_F1]
			== $past(psw_r[cms_pkg::PSW_CY:cms_pkg::PSW_F1]))
		else $error("status flags changed without cause");

endmodule
`default_nettype wire

// *** core_status_and_data_memory_map_bench.sv ***
// Self-checking bench for the status word and data memory map block.
// Assumes cms_pkg and cms_core_map are compiled first; inputs change on falling edges.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("unexpected %s expected %h seen %h", nm, e, g); \
	end \
end

module core_status_and_data_memory_map_bench;
	logic clk;
	logic rst_b;
	logic flash_wr_sel;
	cms_pkg::cms_req_t req;
	cms_pkg::cms_rsp_t rsp;
	cms_pkg::cms_flash_t flash;
	cms_pkg::cms_rsp_t rsp_q;
	cms_pkg::cms_flash_t fl_q;
	logic [7:0] program_status_word;
	logic [7:0] sp;
	logic [7:0] acc;
	int fails = 0;
	int samples_checked = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and device
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	cms_core_map #(.LARGE_VARIANT(1'b1)) i_dut (
		.CLK_IN(clk),
		.RST_B_IN(rst_b),
		.REQ_IN(req),
		.FLASH_WR_SEL_IN(flash_wr_sel),
		.RSP_OUT(rsp),
		.FLASH_REQ_OUT(flash),
		.PSW_OUT(program_status_word),
		.SP_OUT(sp),
		.ACC_OUT(acc)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Access tasks
	// One request per call; the next call replaces it, so no op is ever seen twice
	task automatic issue(input cms_pkg::cms_op_t op, input logic [15:0] a, input logic [7:0] w,
		input logic ps, input logic dp);
		req <= '{op, a, w, ps, dp};
		@(posedge clk);
		@(negedge clk);
		rsp_q = rsp; // Valid pulse lasts one cycle, so it is caught here
		fl_q = flash;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		issue(cms_pkg::OP_DIR_WR, {8'h00, a}, w, 1'b0, 1'b0);
	endtask

	task automatic rd(input cms_pkg::cms_op_t op, input logic [15:0] a, input logic ps,
		input logic dp, input logic [7:0] e);
		issue(op, a, 8'h00, ps, dp);
		`CHK("read valid", 1'b1, rsp_q.valid)
		`CHK("read data", e, rsp_q.rdata)
	endtask

	// Presets status, accumulator and B, runs one op; parity is derived from the result
	task automatic arith(input cms_pkg::cms_op_t op, input logic [7:0] p0, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] w, input logic [7:0] e_acc, input logic [7:0] e_b,
		input logic [7:0] e_fl, input logic [7:0] mask);
		wr(cms_pkg::SFR_PSW, p0);
		wr(cms_pkg::SFR_ACC, a);
		wr(cms_pkg::SFR_B, b);
		issue(op, 16'h0000, w, 1'b0, 1'b0);
		`CHK("accumulator", e_acc, acc)
		`CHK("status flags", {e_fl[7:1], ^e_acc} & mask, program_status_word & mask)
		rd(cms_pkg::OP_DIR_RD, {8'h00, cms_pkg::SFR_B}, 1'b0, 1'b0, e_b);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: about 110 transfers of one clock cycle each, so 3000 rising edges is ample
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		req = '0;
		flash_wr_sel = 1'b0;
		rst_b = 1'b0;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		`CHK("status reset", 8'h00, program_status_word)
		`CHK("stack reset", 8'h07, sp)
		`CHK("acc reset", 8'h00, acc)
		// Stack: pre-increment push, post-decrement pop, then at the top of RAM
		issue(cms_pkg::OP_PUSH, 16'h0000, 8'h11, 1'b0, 1'b0);
		`CHK("stack after push", 8'h08, sp)
		`CHK("no answer on push", 1'b0, rsp_q.valid)
		rd(cms_pkg::OP_DIR_RD, 16'h0008, 1'b0, 1'b0, 8'h11);
		issue(cms_pkg::OP_PUSH, 16'h0000, 8'h22, 1'b0, 1'b0);
		rd(cms_pkg::OP_POP, 16'h0000, 1'b0, 1'b0, 8'h22);
		rd(cms_pkg::OP_POP, 16'h0000, 1'b0, 1'b0, 8'h11);
		`CHK("stack after pops", 8'h07, sp)
		wr(cms_pkg::SFR_SP, 8'hfe);
		issue(cms_pkg::OP_PUSH, 16'h0000, 8'h33, 1'b0, 1'b0);
		`CHK("stack at top", 8'hff, sp)
		issue(cms_pkg::OP_REG_WR, 16'h0000, 8'hff, 1'b0, 1'b0);
		rd(cms_pkg::OP_IND_RD, 16'h0000, 1'b0, 1'b0, 8'h33);
		rd(cms_pkg::OP_POP, 16'h0000, 1'b0, 1'b0, 8'h33);
		// Arithmetic flags; preset flags show that add, add-carry, multiply and divide clear what they must
		arith(cms_pkg::OP_ADD, 8'h00, 8'h88, 8'h00, 8'h88, 8'h10, 8'h00, 8'hc4, 8'hc5);
		arith(cms_pkg::OP_ADD, 8'hc4, 8'h01, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'hc5);
		arith(cms_pkg::OP_ADDC, 8'h80, 8'h7f, 8'h00, 8'h00, 8'h80, 8'h00, 8'h44, 8'hc5);
		arith(cms_pkg::OP_SUBB, 8'h00, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h00, 8'h44, 8'hc5);
		arith(cms_pkg::OP_SUBB, 8'h80, 8'h00, 8'h00, 8'h01, 8'hfe, 8'h00, 8'hc0, 8'hc5);
		arith(cms_pkg::OP_MUL, 8'h80, 8'h10, 8'h10, 8'h00, 8'h00, 8'h01, 8'h04, 8'h85);
		arith(cms_pkg::OP_MUL, 8'h84, 8'h0f, 8'h11, 8'h00, 8'hff, 8'h00, 8'h00, 8'h85);
		arith(cms_pkg::OP_DIV, 8'h80, 8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'h04, 8'h85);
		arith(cms_pkg::OP_DIV, 8'h84, 8'h07, 8'h02, 8'h00, 8'h03, 8'h01, 8'h00, 8'h85);
		// Each bank value lands at its own byte range
		for (int k = 0; k < 4; k++) begin
			wr(cms_pkg::SFR_PSW, {3'h0, k[1:0], 3'h0});
			issue(cms_pkg::OP_REG_WR, 16'h0002, {6'h10, k[1:0]}, 1'b0, 1'b0);
			rd(cms_pkg::OP_DIR_RD, {11'h000, k[1:0], 3'h2}, 1'b0, 1'b0, {6'h10, k[1:0]});
		end
		// Indirect access through the active bank's pointers
		wr(cms_pkg::SFR_PSW, 8'h08);
		issue(cms_pkg::OP_REG_WR, 16'h0000, 8'h30, 1'b0, 1'b0);
		issue(cms_pkg::OP_REG_WR, 16'h0001, 8'h90, 1'b0, 1'b0);
		issue(cms_pkg::OP_IND_WR, 16'h0000, 8'h5a, 1'b0, 1'b0);
		rd(cms_pkg::OP_DIR_RD, 16'h0030, 1'b0, 1'b0, 8'h5a);
		rd(cms_pkg::OP_DIR_RD, 16'h0000, 1'b0, 1'b0, 8'hff);
		issue(cms_pkg::OP_IND_WR, 16'h0000, 8'ha5, 1'b1, 1'b0);
		wr(8'h90, 8'h3c);
		rd(cms_pkg::OP_DIR_RD, 16'h0090, 1'b0, 1'b0, 8'h00);
		rd(cms_pkg::OP_IND_RD, 16'h0000, 1'b1, 1'b0, 8'ha5);
		// Bit region and status bits
		wr(8'h22, 8'h00);
		wr(8'h2f, 8'h00);
		issue(cms_pkg::OP_BIT_WR, 16'h0013, 8'h01, 1'b0, 1'b0);
		rd(cms_pkg::OP_DIR_RD, 16'h0022, 1'b0, 1'b0, 8'h08);
		issue(cms_pkg::OP_BIT_RD, 16'h0013, 8'h00, 1'b0, 1'b0);
		`CHK("bit read", 1'b1, rsp_q.rdata[0])
		issue(cms_pkg::OP_BIT_WR, 16'h007f, 8'h01, 1'b0, 1'b0);
		rd(cms_pkg::OP_DIR_RD, 16'h002f, 1'b0, 1'b0, 8'h80);
		wr(cms_pkg::SFR_ACC, 8'h07);
		wr(cms_pkg::SFR_PSW, 8'h00);
		`CHK("parity", 8'h01, program_status_word)
		issue(cms_pkg::OP_BIT_WR, 16'h00d5, 8'h01, 1'b0, 1'b0);
		issue(cms_pkg::OP_BIT_WR, 16'h00d1, 8'h01, 1'b0, 1'b0);
		issue(cms_pkg::OP_BIT_WR, 16'h00d0, 8'h00, 1'b0, 1'b0);
		`CHK("soft flags", 8'h23, program_status_word)
		// Expanded RAM by data pointer and by page plus index
		wr(cms_pkg::SFR_DPH, 8'h01);
		wr(cms_pkg::SFR_DPL, 8'h23);
		issue(cms_pkg::OP_XMOV_WR, 16'h0000, 8'h6c, 1'b0, 1'b1);
		wr(cms_pkg::SFR_XPAGE, 8'h01);
		issue(cms_pkg::OP_REG_WR, 16'h0001, 8'h23, 1'b0, 1'b0);
		rd(cms_pkg::OP_XMOV_RD, 16'h0000, 1'b1, 1'b0, 8'h6c);
		// Past 4096 nothing is stored, and nothing aliases onto low bytes
		wr(cms_pkg::SFR_DPH, 8'h11);
		issue(cms_pkg::OP_XMOV_WR, 16'h0000, 8'h77, 1'b0, 1'b1);
		rd(cms_pkg::OP_XMOV_RD, 16'h0000, 1'b0, 1'b1, 8'h00);
		wr(cms_pkg::SFR_DPH, 8'h01);
		rd(cms_pkg::OP_XMOV_RD, 16'h0000, 1'b0, 1'b1, 8'h6c);
		// Redirected write goes to flash and leaves the RAM byte alone
		flash_wr_sel = 1'b1;
		issue(cms_pkg::OP_XMOV_WR, 16'h0000, 8'h99, 1'b0, 1'b1);
		`CHK("flash write", 2'b11, {fl_q.valid, fl_q.write})
		`CHK("flash addr", 24'h012399, {fl_q.addr, fl_q.data})
		flash_wr_sel = 1'b0;
		rd(cms_pkg::OP_XMOV_RD, 16'h0000, 1'b0, 1'b1, 8'h6c);
		// Code reads: lock byte, reserved space, and a shared address
		issue(cms_pkg::OP_CODE_RD, 16'hfbff, 8'h00, 1'b0, 1'b0);
		`CHK("lock byte", 4'ha, {fl_q.valid, fl_q.write, fl_q.lock_hit, fl_q.reserved})
		issue(cms_pkg::OP_CODE_RD, 16'hfc00, 8'h00, 1'b0, 1'b0);
		`CHK("reserved", 4'h9, {fl_q.valid, fl_q.write, fl_q.lock_hit, fl_q.reserved})
		issue(cms_pkg::OP_CODE_RD, 16'h0123, 8'h00, 1'b0, 1'b0);
		`CHK("code read", 20'h80123, {fl_q.valid, 3'h0, fl_q.addr})
		rd(cms_pkg::OP_XMOV_RD, 16'h0000, 1'b0, 1'b1, 8'h6c);
		issue(cms_pkg::OP_NOP, 16'h0000, 8'h00, 1'b0, 1'b0);
		results();
	end
endmodule

`default_nettype wire
